// >>> tb/eimv_cpu_model.sv
// CPU-side APB master model that reaches the block's registers.
`timescale 1ns/1ps
`default_nettype none

module eimv_cpu_model
	import eimv_pkg::*;
(
	// Clock and slave answer.
	input  wire logic              clk_in,
	input  wire logic [DATA_W-1:0] prdata_in,
	input  wire logic              pready_in,
	input  wire logic              pslverr_in,
	// Request to the slave.
	output logic                   psel_out,
	output logic                   penable_out,
	output logic                   pwrite_out,
	output logic      [ADDR_W-1:0] paddr_out,
	output logic      [DATA_W-1:0] pwdata_out
);
	// The bus is idle at time zero.
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = '0;
		pwdata_out = '0;
	end

	// One transfer, entered just after a rising edge; it waits for pready without a cycle count.
	task automatic xfer(input logic wr, input logic [15:0] idx, input logic [DATA_W-1:0] wd,
			output logic [DATA_W-1:0] rd, output logic err);
		psel_out <= 1'b1;
		penable_out <= 1'b0;
		pwrite_out <= wr;
		paddr_out <= {idx, 2'b00};
		pwdata_out <= wd;
		@(posedge clk_in);
		penable_out <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready_in !== 1'b1);
		rd = prdata_in;
		err = pslverr_in;
		// Released address and write-data lines show the inverse, so no stale value can pass for an answer.
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		paddr_out <= ~paddr_out;
		pwdata_out <= ~pwdata_out;
		@(posedge clk_in);
	endtask
endmodule

`default_nettype wire

// >>> tb/tb_event_irq_mask_vector.sv
// Self-checking bench for the event interrupt mask and vector block.
`timescale 1ns/1ps
`default_nettype none

module tb_event_irq_mask_vector
	import eimv_pkg::*;
;
	logic              core_clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [NUM_A-1:0]  ev_a, fa, ma;
	logic [NUM_B-1:0]  ev_b, fb, mb;
	logic [NUM_C-1:0]  ev_c, fc, mc;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, q, w, st;
	int                mismatches, n_tests, cyc;

	eimv_top uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .grp_a_event_in(ev_a),
		.grp_b_event_in(ev_b), .cap_event_in(ev_c), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .irq_out(irq));
	eimv_cpu_model cpu (.clk_in(core_clk_in), .prdata_in(prdata), .pready_in(pready),
		.pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
		.paddr_out(paddr), .pwdata_out(pwdata));

	// A 20 ns clock.
	initial begin
		core_clk_in = 1'b0;
		forever #10 core_clk_in = ~core_clk_in;
	end

	// Xorshift source of stimulus.
	function automatic logic [31:0] xs();
		st ^= st << 13;
		st ^= st >> 17;
		st ^= st << 5;
		return st;
	endfunction

	// Lowest set bit wins; its ID is the group base plus the bit number.
	function automatic logic [31:0] exp_vec(input logic [15:0] f, input logic [VEC_W-1:0] base);
		for (int n = 0; n < 16; n++) begin
			if (f[n]) return 32'(base + VEC_W'(n));
		end
		return 32'h0000_0000;
	endfunction

	// Compares one value and reports a mismatch.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// Register read and write, both expecting no error.
	task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
		cpu.xfer(1'b0, idx, 32'h0000_0000, q, e);
		chk($sformatf("reg %h", idx), q, exp);
		chk("err", 32'(e), 32'h0000_0000);
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		cpu.xfer(1'b1, idx, d, q, e);
		chk("werr", 32'(e), 32'h0000_0000);
	endtask

	task automatic final_report();
		if (mismatches == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Hang guard.
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 8000) begin
			mismatches++;
			final_report();
		end
	end

	// Main sequence.
	initial begin
		st = 32'h0000_0025;
		rst_n_in = 1'b0;
		{ev_a, ev_b, ev_c, fa, fb, fc} = '0;
		repeat (16) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		@(posedge core_clk_in);
		// Every register starts at zero.
		rd(IDX_MASK_A, 0);
		rd(IDX_MASK_B, 0);
		rd(IDX_MASK_C, 0);
		rd(IDX_FLAG_A, 0);
		rd(IDX_FLAG_B, 0);
		rd(IDX_FLAG_C, 0);
		// Unmapped place answers with an error and zero data.
		cpu.xfer(1'b0, 16'h7450, 32'h0000_0000, q, e);
		chk("unmapped err", 32'(e), 32'h0000_0001);
		chk("unmapped data", q, 32'h0000_0000);
		// Vector registers ignore writes and read zero.
		wr(IDX_VEC_A, 32'hFFFF_FFFF);
		wr(IDX_VEC_C, 32'hFFFF_FFFF);
		rd(IDX_VEC_A, 0);
		rd(IDX_VEC_B, 0);
		rd(IDX_VEC_C, 0);
		// A capture event at the edge of a clearing write wins over the clear.
		fork
			wr(IDX_FLAG_C, 32'h0000_000F);
			begin
				@(posedge core_clk_in);
				ev_c <= 4'h1;
				@(posedge core_clk_in);
				ev_c <= 4'h0;
			end
		join
		fc = 4'h1;
		rd(IDX_FLAG_C, 32'h0000_0001);
		repeat (40) begin
			w = xs();
			ma = w[NUM_A-1:0];
			wr(IDX_MASK_A, w);
			w = xs();
			mb = w[NUM_B-1:0];
			wr(IDX_MASK_B, w);
			w = xs();
			mc = w[NUM_C-1:0];
			wr(IDX_MASK_C, w);
			rd(IDX_MASK_A, 32'(ma));
			rd(IDX_MASK_B, 32'(mb));
			rd(IDX_MASK_C, 32'(mc));
			// Sparse one-cycle event pulses.
			w = xs() & xs();
			ev_a <= w[10:0];
			ev_b <= w[18:11];
			ev_c <= w[22:19];
			fa |= w[10:0];
			fb |= w[18:11];
			fc |= w[22:19];
			@(posedge core_clk_in);
			{ev_a, ev_b, ev_c} <= '0;
			repeat (3) @(posedge core_clk_in);
			chk("irq", 32'(irq), 32'(|{fa & ma, fb & mb, fc & mc}));
			rd(IDX_FLAG_C, 32'(fc));
			rd(IDX_FLAG_A, 32'(fa));
			rd(IDX_FLAG_B, 32'(fb));
			rd(IDX_VEC_A, exp_vec(16'(fa & ma), ID_BASE_A));
			rd(IDX_VEC_B, exp_vec(16'(fb & mb), ID_BASE_B));
			rd(IDX_VEC_C, exp_vec(16'(fc & mc), ID_BASE_C));
			// Clearing some flags; zeros leave the others set.
			w = xs();
			wr(IDX_FLAG_A, w);
			wr(IDX_FLAG_B, w);
			wr(IDX_FLAG_C, w);
			fa &= ~w[10:0];
			fb &= ~w[7:0];
			fc &= ~w[3:0];
			// The line follows the cleared flags one edge later.
			@(posedge core_clk_in);
			chk("irq after clear", 32'(irq), 32'(|{fa & ma, fb & mb, fc & mc}));
		end
		// Reset in mid-run brings every register back to zero.
		rst_n_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		@(posedge core_clk_in);
		rd(IDX_MASK_A, 0);
		rd(IDX_MASK_C, 0);
		rd(IDX_FLAG_C, 0);
		rd(IDX_VEC_A, 0);
		rd(IDX_VEC_C, 0);
		chk("irq after reset", 32'(irq), 32'h0000_0000);
		final_report();
	end
endmodule

`default_nettype wire

// >>> verilog/eimv_pkg.sv
// Constants and types for the event interrupt mask and vector block.
package eimv_pkg;

	// APB address width; registers sit at byte address four times the index.
	localparam int unsigned ADDR_W = 18;
	localparam int unsigned DATA_W = 32;

	// Register indices.
	localparam logic [15:0] IDX_MASK_A = 16'h742C;
	localparam logic [15:0] IDX_MASK_B = 16'h742D;
	localparam logic [15:0] IDX_MASK_C = 16'h742E;
	localparam logic [15:0] IDX_FLAG_C = 16'h7431;
	localparam logic [15:0] IDX_VEC_A  = 16'h7432;
	localparam logic [15:0] IDX_VEC_B  = 16'h7433;
	localparam logic [15:0] IDX_VEC_C  = 16'h7434;
	localparam logic [15:0] IDX_FLAG_A = 16'h7440;
	localparam logic [15:0] IDX_FLAG_B = 16'h7441;

	// Number of flag sources per group and the vector width; fields start at bit 0.
	localparam int unsigned NUM_A  = 11;
	localparam int unsigned NUM_B  = 8;
	localparam int unsigned NUM_C  = 4;
	localparam int unsigned VEC_W  = 6;

	// Reset values.
	localparam logic [NUM_A-1:0] RST_A   = 11'h000;
	localparam logic [NUM_B-1:0] RST_B   = 8'h00;
	localparam logic [NUM_C-1:0] RST_C   = 4'h0;
	localparam logic [VEC_W-1:0] RST_VEC = 6'h00;

	// First ID of each group; source n of a group has ID base plus n.
	localparam logic [VEC_W-1:0] ID_BASE_A = 6'h01;
	localparam logic [VEC_W-1:0] ID_BASE_B = 6'h11;
	localparam logic [VEC_W-1:0] ID_BASE_C = 6'h21;

	// Bus answer phase.
	typedef enum logic [0:0] {
		EIMV_PH_IDLE = 1'b0,
		EIMV_PH_ACK  = 1'b1
	} eimv_phase_t;

	// Whole state of the block.
	typedef struct packed {
		logic [NUM_A-1:0]  mask_a;
		logic [NUM_B-1:0]  mask_b;
		logic [NUM_C-1:0]  mask_c;
		logic [NUM_A-1:0]  flag_a;
		logic [NUM_B-1:0]  flag_b;
		logic [NUM_C-1:0]  flag_c;
		logic [VEC_W-1:0]  vec_a;
		logic [VEC_W-1:0]  vec_b;
		logic [VEC_W-1:0]  vec_c;
		eimv_phase_t       phase;
		logic [DATA_W-1:0] prdata;
		logic              pslverr;
		logic              irq;
	} eimv_state_t;

	localparam eimv_state_t RST_STATE = '{
		mask_a: RST_A, mask_b: RST_B, mask_c: RST_C,
		flag_a: RST_A, flag_b: RST_B, flag_c: RST_C,
		vec_a: RST_VEC, vec_b: RST_VEC, vec_c: RST_VEC,
		phase: EIMV_PH_IDLE, prdata: 32'h0000_0000,
		pslverr: 1'b0, irq: 1'b0
	};

endpackage

// >>> verilog/eimv_top.sv
// Event interrupt flags, masks and priority vectors behind an APB slave.
`timescale 1ns/1ps
`default_nettype none

module eimv_top
	import eimv_pkg::*;
(
	// Clock and synchronous active-low reset.
	input  wire logic              core_clk_in,
	input  wire logic              rst_n_in,
	// Event sources, one bit per flag, high for each event.
	input  wire logic [NUM_A-1:0]  grp_a_event_in,
	input  wire logic [NUM_B-1:0]  grp_b_event_in,
	input  wire logic [NUM_C-1:0]  cap_event_in,
	// APB slave.
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [ADDR_W-1:0] paddr_in,
	input  wire logic [DATA_W-1:0] pwdata_in,
	output logic      [DATA_W-1:0] prdata_out,
	output logic                   pready_out,
	output logic                   pslverr_out,
	// Level interrupt request to the CPU.
	output logic                   irq_out
);

	// True when the word index of the address equals a register index.
	function automatic logic eimv_hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
		return addr[ADDR_W-1:2] == idx;
	endfunction

	// Priority pick: lowest set bit wins, ID is base plus bit number.
	function automatic logic [VEC_W-1:0] eimv_pick(input logic [15:0] pend, input logic [VEC_W-1:0] base);
		logic [VEC_W-1:0] id;
		id = RST_VEC;
		for (int i = 15; i >= 0; i--) begin
			if (pend[i]) begin
				id = base + VEC_W'(i);
			end
		end
		return id;
	endfunction

	eimv_state_t s;      // Registered state.
	eimv_state_t next_s; // Next state.

	logic             setup;  // Setup cycle of an APB transfer.
	logic             wr_acc; // Write completes at this edge.
	logic [NUM_A-1:0] pend_a; // Set and enabled group-A flags.
	logic [NUM_B-1:0] pend_b; // Set and enabled group-B flags.
	logic [NUM_C-1:0] pend_c; // Set and enabled capture flags.
	logic [NUM_A-1:0] clr_a;  // Write-one-clear pattern for group A.
	logic [NUM_B-1:0] clr_b;  // Write-one-clear pattern for group B.
	logic [NUM_C-1:0] clr_c;  // Write-one-clear pattern for capture flags.

	// Pending terms feed both the vectors and the interrupt line.
	assign pend_a = s.flag_a & s.mask_a;
	assign pend_b = s.flag_b & s.mask_b;
	assign pend_c = s.flag_c & s.mask_c;
	assign setup  = psel_in && !penable_in;
	assign wr_acc = psel_in && penable_in && (s.phase == EIMV_PH_ACK) && pwrite_in;

	// Clear patterns apply only on a completed write to the flag register.
	always_comb begin
		clr_a = RST_A;
		clr_b = RST_B;
		clr_c = RST_C;
		if (wr_acc && eimv_hit(paddr_in, IDX_FLAG_A)) begin
			clr_a = pwdata_in[NUM_A-1:0];
		end
		if (wr_acc && eimv_hit(paddr_in, IDX_FLAG_B)) begin
			clr_b = pwdata_in[NUM_B-1:0];
		end
		if (wr_acc && eimv_hit(paddr_in, IDX_FLAG_C)) begin
			clr_c = pwdata_in[NUM_C-1:0];
		end
	end

	// Next-state logic for registers, vectors, interrupt and bus answer.
	always_comb begin
		next_s = s;
		// An event in the clearing cycle wins over the clear.
		next_s.flag_a = (s.flag_a & ~clr_a) | grp_a_event_in;
		next_s.flag_b = (s.flag_b & ~clr_b) | grp_b_event_in;
		next_s.flag_c = (s.flag_c & ~clr_c) | cap_event_in;
		// Mask writes; upper bits are dropped so they read as zero.
		if (wr_acc && eimv_hit(paddr_in, IDX_MASK_A)) begin
			next_s.mask_a = pwdata_in[NUM_A-1:0];
		end
		if (wr_acc && eimv_hit(paddr_in, IDX_MASK_B)) begin
			next_s.mask_b = pwdata_in[NUM_B-1:0];
		end
		if (wr_acc && eimv_hit(paddr_in, IDX_MASK_C)) begin
			next_s.mask_c = pwdata_in[NUM_C-1:0];
		end
		// Vectors follow the pending flags; writes never reach them.
		next_s.vec_a = eimv_pick({5'h00, pend_a}, ID_BASE_A);
		next_s.vec_b = eimv_pick({8'h00, pend_b}, ID_BASE_B);
		next_s.vec_c = eimv_pick({12'h000, pend_c}, ID_BASE_C);
		// Interrupt is high while any enabled flag is set.
		next_s.irq = (|pend_a) || (|pend_b) || (|pend_c);
		// Ready rises in the first access cycle after every setup.
		next_s.phase = setup ? EIMV_PH_ACK : EIMV_PH_IDLE;
		// Read data and error are captured in the setup cycle.
		if (setup) begin
			next_s.prdata  = 32'h0000_0000;
			next_s.pslverr = 1'b0;
			if (eimv_hit(paddr_in, IDX_MASK_A)) begin
				next_s.prdata[NUM_A-1:0] = s.mask_a;
			end else if (eimv_hit(paddr_in, IDX_MASK_B)) begin
				next_s.prdata[NUM_B-1:0] = s.mask_b;
			end else if (eimv_hit(paddr_in, IDX_MASK_C)) begin
				next_s.prdata[NUM_C-1:0] = s.mask_c;
			end else if (eimv_hit(paddr_in, IDX_FLAG_A)) begin
				next_s.prdata[NUM_A-1:0] = s.flag_a;
			end else if (eimv_hit(paddr_in, IDX_FLAG_B)) begin
				next_s.prdata[NUM_B-1:0] = s.flag_b;
			end else if (eimv_hit(paddr_in, IDX_FLAG_C)) begin
				next_s.prdata[NUM_C-1:0] = s.flag_c;
			end else if (eimv_hit(paddr_in, IDX_VEC_A)) begin
				next_s.prdata[VEC_W-1:0] = s.vec_a;
			end else if (eimv_hit(paddr_in, IDX_VEC_B)) begin
				next_s.prdata[VEC_W-1:0] = s.vec_b;
			end else if (eimv_hit(paddr_in, IDX_VEC_C)) begin
				next_s.prdata[VEC_W-1:0] = s.vec_c;
			end else begin
				// Unmapped address answers with an error and zero data.
				next_s.pslverr = 1'b1;
			end
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			s <= RST_STATE;
		end else begin
			s <= next_s;
		end
	end

	// Outputs come straight from the state register.
	assign prdata_out  = s.prdata;
	assign pready_out  = (s.phase == EIMV_PH_ACK);
	assign pslverr_out = s.pslverr;
	assign irq_out     = s.irq;

	// A completed write sets the capture mask to the low four data bits.
	mask_c_write_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(wr_acc && eimv_hit(paddr_in, IDX_MASK_C)) |=> (s.mask_c == $past(pwdata_in[NUM_C-1:0])))
		else $error("capture mask not written");

	// A disabled capture flag never raises the vector.
	mask_c_gate_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(s.flag_c == 4'h1 && !s.mask_c[0]) |=> (s.vec_c == RST_VEC))
		else $error("disabled capture flag reached vector");

	// Group-A vector is zero with nothing pending and shows bit 0 first.
	vec_a_zero_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(pend_a == RST_A) |=> (s.vec_a == RST_VEC))
		else $error("group A vector not zero");

	vec_a_prio_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		pend_a[0] |=> (s.vec_a == ID_BASE_A))
		else $error("group A priority wrong");

	// Group-B vector shows source 7 when it is the only pending source.
	vec_b_top_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(pend_b == 8'h80) |=> (s.vec_b == ID_BASE_B + 6'h07))
		else $error("group B vector wrong");

	// Capture vector is zero when nothing is pending, else in its ID range.
	vec_c_range_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(pend_c != RST_C) |=> (s.vec_c >= ID_BASE_C && s.vec_c <= ID_BASE_C + 6'h03))
		else $error("capture vector out of range");

	vec_c_zero_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(pend_c == RST_C) |=> (s.vec_c == RST_VEC))
		else $error("capture vector not zero");

	// Capture vector reads carry zero above bit 5 and match the vector.
	vec_read_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(setup && eimv_hit(paddr_in, IDX_VEC_C)) |=>
			(prdata_out[DATA_W-1:VEC_W] == 26'h0000000 && prdata_out[VEC_W-1:0] == $past(s.vec_c)))
		else $error("vector read wrong");

	// Write one clears a capture flag unless an event arrives.
	flag_c_clear_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(wr_acc && eimv_hit(paddr_in, IDX_FLAG_C) && pwdata_in[0] && !cap_event_in[0]) |=> !s.flag_c[0])
		else $error("capture flag not cleared");

	flag_c_set_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		cap_event_in[0] |=> s.flag_c[0])
		else $error("capture event lost");

	// Group-A mask write lands and steers the interrupt line.
	mask_a_write_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(wr_acc && eimv_hit(paddr_in, IDX_MASK_A)) |=> (s.mask_a == $past(pwdata_in[NUM_A-1:0])))
		else $error("group A mask not written");

	irq_level_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		((pend_a | {3'h0, pend_b}) != RST_A) |=> irq_out)
		else $error("interrupt not raised");

	// Ready answers exactly one cycle after setup.
	apb_ready_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		setup |=> pready_out ##1 !pready_out)
		else $error("ready timing wrong");

	// A completed write sets the group-B mask to the low eight data bits.
	mask_b_write_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(wr_acc && eimv_hit(paddr_in, IDX_MASK_B)) |=> (s.mask_b == $past(pwdata_in[NUM_B-1:0])))
		else $error("group B mask not written");

	// Group-B vector is zero with nothing pending.
	vec_b_zero_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(pend_b == RST_B) |=> (s.vec_b == RST_VEC))
		else $error("group B vector not zero");

	// Bit 0 is the highest priority source of group B.
	vec_b_prio_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		pend_b[0] |=> (s.vec_b == ID_BASE_B))
		else $error("group B priority wrong");

	// Bit 0 is the highest priority capture source.
	vec_c_prio_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		pend_c[0] |=> (s.vec_c == ID_BASE_C))
		else $error("capture priority wrong");

	// Group-A vector stays inside the group's ID range while anything is pending.
	vec_a_range_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(pend_a != RST_A) |=> (s.vec_a >= ID_BASE_A && s.vec_a <= ID_BASE_A + 6'h0A))
		else $error("group A vector out of range");

	// A write to a vector register touches no mask and answers without error.
	vec_write_nop_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(wr_acc && (eimv_hit(paddr_in, IDX_VEC_A) || eimv_hit(paddr_in, IDX_VEC_B) ||
			eimv_hit(paddr_in, IDX_VEC_C))) |=>
			($stable(s.mask_a) && $stable(s.mask_b) && $stable(s.mask_c) && !pslverr_out))
		else $error("vector write had an effect");

	// Group-A and group-B vector reads carry zero above bit 5.
	vec_a_read_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(setup && eimv_hit(paddr_in, IDX_VEC_A)) |=> (prdata_out == DATA_W'($past(s.vec_a))))
		else $error("group A vector read wrong");

	vec_b_read_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(setup && eimv_hit(paddr_in, IDX_VEC_B)) |=> (prdata_out == DATA_W'($past(s.vec_b))))
		else $error("group B vector read wrong");

	// Capture flag reads show the flags with zero above bit 3.
	flag_c_read_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(setup && eimv_hit(paddr_in, IDX_FLAG_C)) |=> (prdata_out == DATA_W'($past(s.flag_c))))
		else $error("capture flag read wrong");

	// Capture mask reads show the mask with zero above bit 3.
	mask_c_read_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(setup && eimv_hit(paddr_in, IDX_MASK_C)) |=> (prdata_out == DATA_W'($past(s.mask_c))))
		else $error("capture mask read wrong");

	// Writing zero to a set capture flag leaves it set.
	flag_c_hold_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(wr_acc && eimv_hit(paddr_in, IDX_FLAG_C) && !pwdata_in[0] && s.flag_c[0]) |=> s.flag_c[0])
		else $error("capture flag lost on zero write");

	// The interrupt line drops when no enabled flag is set.
	irq_clear_a: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(pend_a == RST_A && pend_b == RST_B && pend_c == RST_C) |=> !irq_out)
		else $error("interrupt stuck high");

	// Reset leaves every vector and the capture mask at zero.
	reset_zero_a: assert property (
		@(posedge core_clk_in)
		!rst_n_in |=> (s.vec_a == RST_VEC && s.vec_b == RST_VEC &&
			s.vec_c == RST_VEC && s.mask_c == RST_C))
		else $error("reset value wrong");

endmodule

`default_nettype wire
